// ### src/agc_cal_pkg.sv
package agc_cal_pkg;

  // Timing, expressed in microseconds and derived to cycles
  localparam int CLK_MHZ    = 100;
  localparam int SETTLE_US  = 3000;
  localparam int GAP_US     = 500;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int GAP_CYC    = GAP_US * CLK_MHZ;
  localparam int TMR_W      = 20;

  // Device register addresses on the device access port
  localparam logic [6:0] DEV_FILTER     = 7'h01;
  localparam logic [6:0] DEV_GAIN_TWO   = 7'h02;
  localparam logic [6:0] DEV_GAIN_THREE = 7'h03;
  localparam logic [6:0] DEV_GAIN_FOUR  = 7'h04;
  localparam logic [6:0] DEV_STRENGTH   = 7'h05;
  localparam logic [6:0] DEV_STATUS     = 7'h06;
  localparam logic [6:0] DEV_PHASE_COMP = 7'h07;
  localparam logic [6:0] DEV_GAIN_COMP  = 7'h08;

  // Device values used by the two procedures
  localparam logic [7:0] GAIN_TWO_OFF  = 8'hbf;
  localparam logic [7:0] GAIN_TWO_HIGH = 8'h55;
  localparam logic [7:0] GAIN_TWO_LOW  = 8'h45;
  localparam logic [4:0] SETTING_MAX   = 5'h1f;
  localparam logic [4:0] SETTING_SPLIT = 5'h0a;
  localparam logic [6:0] NOISE_RISE    = 7'h04;
  localparam logic [6:0] CS_BACKOFF    = 7'h08;
  localparam int         CS_BIT        = 3;
  localparam logic [6:0] DX_INIT       = 7'h40;
  localparam int         COMP_CEIL     = 127;
  localparam int         AVG_READS     = 8;

  // Own APB register map, byte offsets
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_RESULT = 12'h008;
  localparam logic [11:0] A_FILTER = 12'h00c;
  localparam logic [11:0] A_MARGIN = 12'h010;

  // Field positions and the filter reset value
  localparam int CTRL_AGC  = 0;
  localparam int CTRL_CAL  = 1;
  localparam int CTRL_CONT = 2;
  localparam int ST_BUSY   = 0;
  localparam int ST_HOLD   = 1;
  localparam int ST_CSENSE = 2;
  localparam int ST_DONE   = 3;
  localparam int FILTER_RST = 8'h00;

endpackage

// ### src/strength_average.sv
`timescale 1ns/10ps
module strength_average
  import agc_cal_pkg::*;
#(
  parameter int N  = AVG_READS,
  parameter int SW = 7,
  parameter int AW = 10
)(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst,
  // Samples
  input  wire logic          clr,
  input  wire logic          add,
  input  wire logic [SW-1:0] sample,
  // Result
  output logic      [AW-1:0] sum,
  output logic               full
);

  typedef struct packed {
    logic [AW-1:0] sum;
    logic [4:0]    cnt;
  } avg_t;

  avg_t r, n;

  // The sum stands in for the mean; the ratio math is scale free
  always_comb
  begin
    n = r;
    if (clr)
    begin
      n.sum = '0;
      n.cnt = '0;
    end
    else if (add && r.cnt != 5'(N))
    begin
      n.sum = r.sum + AW'(sample);
      n.cnt = r.cnt + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign sum  = r.sum;
  assign full = (r.cnt == 5'(N));

  a_avg_count: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(full) |-> $past(r.cnt) == 5'(N - 1) && $past(add))
    else $error("average full without exact sample count");

endmodule

// ### src/apb_regs.sv
`timescale 1ns/10ps
module apb_regs
  import agc_cal_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Commands and configuration
  output logic             go_agc,
  output logic             go_cal,
  output logic             go_cont,
  output logic      [7:0]  filter_cfg,
  output logic      [2:0]  margin_up,
  output logic      [2:0]  margin_down,
  // Status from the sequencer
  input  wire logic [3:0]  status,
  input  wire logic [31:0] result
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        err;
    logic [7:0]  filter;
    logic [6:0]  margin;
    logic [2:0]  go;
  } regs_t;

  regs_t r, n;
  logic  setup;
  logic  hit;

  assign setup = psel && !penable;

  always_comb
  begin
    n    = r;
    n.go = 3'h0;
    hit  = (paddr == A_CTRL) || (paddr == A_STATUS) ||
           (paddr == A_RESULT) || (paddr == A_FILTER) ||
           (paddr == A_MARGIN);
    // Answer prepared in setup so that access needs no wait state
    if (setup)
    begin
      n.err   = !hit;
      n.rdata = '0;
      if (!pwrite)
        case (paddr)
          A_STATUS: n.rdata = {28'h0, status};
          A_RESULT: n.rdata = result;
          A_FILTER: n.rdata = {24'h0, r.filter};
          A_MARGIN: n.rdata = {25'h0, r.margin};
          default:  n.rdata = '0;
        endcase
    end
    if (psel && penable && pwrite)
      case (paddr)
        A_CTRL:   n.go     = pwdata[2:0];
        A_FILTER: n.filter = pwdata[7:0];
        A_MARGIN: n.margin = pwdata[6:0];
        default:  n.go     = 3'h0;
      endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r        <= '0;
      r.filter <= 8'(FILTER_RST);
    end
    else
      r <= n;
  end

  assign prdata      = r.rdata;
  assign pslverr     = r.err;
  assign pready      = psel && penable;
  assign go_agc      = r.go[CTRL_AGC];
  assign go_cal      = r.go[CTRL_CAL];
  assign go_cont     = r.go[CTRL_CONT];
  assign filter_cfg  = r.filter;
  assign margin_up   = r.margin[2:0];
  assign margin_down = r.margin[6:4];

endmodule

// ### src/agc_cal_ctrl.sv
// Function
// - Filter bypass bit skips analog filter; set for 76.8 kBaud and up.
// - Calibration starts phase 0, gain 0, step 64, no halving first.
// - Estimate plus twice the step is written as 127 when not below 127.
// - Wait 3 ms after each write, then average 8 reads 0.5 ms apart.
// - Measure five points, form curvature, rounded correction, clamp to step.
// - Tune phase then gain; halve step while above 1; write final values.
// - Setup starts writing BFh to gain control two, then code zero.
// - Raise maximum-gain code until strength is about 4 over noise floor.
// - With threshold signal applied, write strength minus 8 as threshold.
// - Finish by writing 55h when code exceeds 10, else 45h.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/10ps
module agc_cal_ctrl
  import agc_cal_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int GAP_CYCLES    = GAP_CYC
)(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device register access
  output logic             dreq,
  output logic             dwr,
  output logic      [6:0]  daddr,
  output logic      [7:0]  dwdata,
  input  wire logic        dack,
  input  wire logic [7:0]  drdata
);

  typedef enum logic [4:0] {
    S_IDLE   = 5'h00, S_ACC    = 5'h01, S_DONE   = 5'h02,
    A_CODE   = 5'h03, A_SETTLE = 5'h04, A_EVAL   = 5'h05,
    A_HOLD   = 5'h06, A_CS     = 5'h07, A_STAT   = 5'h08,
    A_FIN    = 5'h09, C_HALVE  = 5'h0a, C_PASS   = 5'h0b,
    C_POINT  = 5'h0c, C_WAIT   = 5'h0d, C_ACCUM  = 5'h0e,
    C_CHECK  = 5'h0f, C_SOLVE  = 5'h10, C_FING   = 5'h11
  } st_t;

  typedef struct packed {
    st_t              st;
    st_t              ret;
    logic             acc_wr;
    logic [6:0]       acc_addr;
    logic [7:0]       acc_data;
    logic [TMR_W-1:0] tmr;
    logic [7:0]       rd;
    logic signed [8:0] xp;
    logic signed [8:0] xg;
    logic [6:0]       dx;
    logic             sel;
    logic [2:0]       k;
    logic [4:0][9:0]  ys;
    logic [4:0]       setting;
    logic [6:0]       floor_v;
    logic             floor_ok;
    logic [4:0]       cs;
    logic             csense;
    logic             done;
  } state_t;

  state_t r, n;

  logic       go_agc;
  logic       go_cal;
  logic       go_cont;
  logic [7:0] filter_cfg;
  logic [2:0] margin_up;
  logic [2:0] margin_down;
  logic       avg_clr;
  logic       avg_add;
  logic [9:0] avg_sum;
  logic       avg_full;
  int         est;
  int         pt;
  int         corr;

  apb_regs u_regs (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .go_agc      (go_agc),
    .go_cal      (go_cal),
    .go_cont     (go_cont),
    .filter_cfg  (filter_cfg),
    .margin_up   (margin_up),
    .margin_down (margin_down),
    .status      ({r.done, r.csense, r.st == A_HOLD, r.st != S_IDLE}),
    .result      ({3'h0, r.cs, 3'h0, r.setting, r.xg[7:0], r.xp[7:0]})
  );

  strength_average u_avg (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr     (avg_clr),
    .add     (avg_add),
    .sample  (r.rd[6:0]),
    .sum     (avg_sum),
    .full    (avg_full)
  );

  function automatic state_t issue(state_t s, logic wr, logic [6:0] a,
                                   logic [7:0] d, st_t ret);
    s.st       = S_ACC;
    s.acc_wr   = wr;
    s.acc_addr = a;
    s.acc_data = d;
    s.ret      = ret;
    return s;
  endfunction

  // Rounded, clamped step from five points; sums stand in for means
  function automatic int correction(logic [4:0][9:0] y, logic [6:0] dx);
    int ap;
    int num;
    int d;
    int q;
    ap  = 2 * (int'(y[0]) - int'(y[2]) + int'(y[4]))
          - (int'(y[1]) + int'(y[3]));
    num = 7 * int'(dx) * (2 * (int'(y[0]) - int'(y[4]))
          + int'(y[1]) - int'(y[3]));
    d   = 10 * ap;
    if (ap > 0)
      q = (num >= 0) ? (2 * num + d) / (2 * d)
                     : -((d - 2 * num) / (2 * d));
    else
      q = (int'(y[0]) + int'(y[1]) > int'(y[3]) + int'(y[4]))
          ? int'(dx) : -int'(dx);
    if (q > int'(dx))
      q = int'(dx);
    else if (q < -int'(dx))
      q = -int'(dx);
    return q;
  endfunction

  always_comb
  begin
    n       = r;
    avg_clr = 1'b0;
    avg_add = 1'b0;
    est     = r.sel ? int'(r.xg) : int'(r.xp);
    pt      = est + (int'(r.k) - 2) * int'(r.dx);
    corr    = correction(r.ys, r.dx);
    case (r.st)
      S_IDLE:
        if (go_agc)
        begin
          n.setting  = 5'h00;
          n.floor_ok = 1'b0;
          n.done     = 1'b0;
          n = issue(n, 1'b1, DEV_GAIN_TWO, GAIN_TWO_OFF, A_CODE);
        end
        else if (go_cal)
        begin
          n.xp   = '0;
          n.xg   = '0;
          n.dx   = DX_INIT;
          n.done = 1'b0;
          n = issue(n, 1'b1, DEV_FILTER, filter_cfg, C_PASS);
        end
      S_ACC:
        if (dack)
        begin
          if (!r.acc_wr)
            n.rd = drdata;
          n.st = r.ret;
        end
      A_CODE:
      begin
        n     = issue(n, 1'b1, DEV_GAIN_THREE, {margin_down, r.setting},
                      A_SETTLE);
        n.tmr = TMR_W'(SETTLE_CYCLES - 1);
      end
      A_SETTLE:
        if (r.tmr == '0)
          n = issue(n, 1'b0, DEV_STRENGTH, 8'h00, A_EVAL);
        else
          n.tmr = r.tmr - 1'b1;
      A_EVAL:
      begin
        // First reading at code zero is the converter noise floor
        if (!r.floor_ok)
        begin
          n.floor_v  = r.rd[6:0];
          n.floor_ok = 1'b1;
        end
        if ((!r.floor_ok || r.rd[6:0] < r.floor_v + NOISE_RISE) &&
            r.setting < SETTING_MAX)
        begin
          n.setting = r.setting + 5'h01;
          n.st      = A_CODE;
        end
        else
          n.st = A_HOLD;
      end
      A_HOLD:
        if (go_cont)
          n = issue(n, 1'b0, DEV_STRENGTH, 8'h00, A_CS);
      A_CS:
      begin
        if (r.rd[6:0] < CS_BACKOFF)
          n.cs = 5'h00;
        else if (r.rd[6:0] - CS_BACKOFF > 7'(SETTING_MAX))
          n.cs = SETTING_MAX;
        else
          n.cs = 5'(r.rd[6:0] - CS_BACKOFF);
        n = issue(n, 1'b1, DEV_GAIN_FOUR, {margin_up, n.cs}, A_STAT);
      end
      A_STAT:
        n = issue(n, 1'b0, DEV_STATUS, 8'h00, A_FIN);
      A_FIN:
      begin
        n.csense = r.rd[CS_BIT];
        n = issue(n, 1'b1, DEV_GAIN_TWO,
                  (r.setting > SETTING_SPLIT) ? GAIN_TWO_HIGH
                                              : GAIN_TWO_LOW,
                  S_DONE);
      end
      S_DONE:
      begin
        n.done = 1'b1;
        n.st   = S_IDLE;
      end
      C_HALVE:
      begin
        n.dx = r.dx >> 1;
        n.st = C_PASS;
      end
      C_PASS:
      begin
        n.sel = 1'b0;
        n.k   = 3'h4;
        n = issue(n, 1'b1, DEV_GAIN_COMP, r.xg[7:0], C_POINT);
      end
      C_POINT:
      begin
        if (r.k == 3'h4 && pt >= COMP_CEIL)
          pt = COMP_CEIL;
        avg_clr = 1'b1;
        n = issue(n, 1'b1, r.sel ? DEV_GAIN_COMP : DEV_PHASE_COMP,
                  pt[7:0], C_WAIT);
        n.tmr = TMR_W'(SETTLE_CYCLES - 1);
      end
      C_WAIT:
        if (r.tmr == '0)
          n = issue(n, 1'b0, DEV_STRENGTH, 8'h00, C_ACCUM);
        else
          n.tmr = r.tmr - 1'b1;
      C_ACCUM:
      begin
        avg_add = 1'b1;
        n.st    = C_CHECK;
      end
      C_CHECK:
        if (avg_full)
        begin
          n.ys[r.k] = avg_sum;
          if (r.k == 3'h0)
            n.st = C_SOLVE;
          else
          begin
            n.k  = r.k - 3'h1;
            n.st = C_POINT;
          end
        end
        else
        begin
          n.tmr = TMR_W'(GAP_CYCLES - 1);
          n.st  = C_WAIT;
        end
      C_SOLVE:
        if (!r.sel)
        begin
          n.xp  = 9'(int'(r.xp) + corr);
          n.sel = 1'b1;
          n.k   = 3'h4;
          n = issue(n, 1'b1, DEV_PHASE_COMP, n.xp[7:0], C_POINT);
        end
        else
        begin
          n.xg = 9'(int'(r.xg) + corr);
          if (r.dx > 7'h01)
            n.st = C_HALVE;
          else
            n = issue(n, 1'b1, DEV_PHASE_COMP, r.xp[7:0], C_FING);
        end
      C_FING:
        n = issue(n, 1'b1, DEV_GAIN_COMP, r.xg[7:0], S_DONE);
      default:
        n.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      r     <= '0;
      r.st  <= S_IDLE;
      r.ret <= S_IDLE;
    end
    else
      r <= n;
  end

  assign dreq   = (r.st == S_ACC);
  assign dwr    = r.acc_wr;
  assign daddr  = r.acc_addr;
  assign dwdata = r.acc_data;

  // Cycles since the last completed device access
  int unsigned since_ack;
  logic        last_wr;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      since_ack <= '0;
      last_wr   <= 1'b0;
    end
    else if (dreq && dack)
    begin
      since_ack <= '0;
      last_wr   <= dwr;
    end
    else if (since_ack != 32'hffffffff)
      since_ack <= since_ack + 1;
  end

  a_req_hold: assert property (@(posedge ref_clk) disable iff (rst)
    dreq && !dack |=> dreq && $stable(daddr) && $stable(dwdata))
    else $error("device request dropped or changed before ack");

  a_cal_start: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == S_IDLE && !go_agc && go_cal |=>
      r.dx == 7'h40 && r.xp == 9'sh0 && r.xg == 9'sh0 && r.ret == C_PASS)
    else $error("calibration did not start at zero and step 64");

  a_point_ceil: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == C_POINT && r.k == 3'h4 && est + 2 * int'(r.dx) >= 127 |=>
      dwdata == 8'h7f)
    else $error("outer point not limited to 127");

  a_settle_wait: assert property (@(posedge ref_clk) disable iff (rst)
    dreq && !dwr && r.ret == C_ACCUM && last_wr |->
      since_ack >= SETTLE_CYCLES - 1)
    else $error("strength read too soon after compensation write");

  a_read_gap: assert property (@(posedge ref_clk) disable iff (rst)
    dreq && !dwr && r.ret == C_ACCUM && !last_wr |->
      since_ack >= GAP_CYCLES - 1)
    else $error("strength reads spaced too closely");

  a_corr_clamp: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == C_SOLVE && !r.sel |=>
      int'(r.xp) - int'($past(r.xp)) <= int'(r.dx) &&
      int'($past(r.xp)) - int'(r.xp) <= int'(r.dx) && r.sel)
    else $error("phase correction exceeds one step");

  a_step_halve: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == C_SOLVE && r.sel && r.dx > 7'h01 |=>
      r.st == C_HALVE ##1 r.dx == $past(r.dx) >> 1)
    else $error("step not halved between passes");

  a_agc_open: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == S_IDLE && go_agc |=>
      dreq && dwr && daddr == DEV_GAIN_TWO && dwdata == 8'hbf
      ##[1:1000] dreq && dwr && daddr == DEV_GAIN_THREE &&
      dwdata[4:0] == 5'h00)
    else $error("setup did not open with BFh then code zero");

  a_noise_raise: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == A_EVAL && r.floor_ok && r.rd[6:0] < r.floor_v + 7'h04 &&
      r.setting < 5'h1f |=> r.setting == $past(r.setting) + 5'h01)
    else $error("gain code not raised below noise target");

  a_cs_write: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == A_CS && r.rd[6:0] >= 7'h08 && r.rd[6:0] < 7'h27 |=>
      dwdata[4:0] == 5'($past(r.rd[6:0]) - 7'h08))
    else $error("threshold not strength minus 8");

  a_agc_finish: assert property (@(posedge ref_clk) disable iff (rst)
    r.st == A_FIN |=>
      dwdata == (r.setting > 5'h0a ? 8'h55 : 8'h45) && daddr == DEV_GAIN_TWO)
    else $error("wrong gain control two value at finish");

endmodule

// ### dv/dev_model.sv
`timescale 1ns/10ps
module dev_model
  import agc_cal_pkg::*;
#(
  parameter int SETTLE = 40,
  parameter int GAP    = 10
)(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Access port
  input  wire logic       dreq,
  input  wire logic       dwr,
  input  wire logic [6:0] daddr,
  input  wire logic [7:0] dwdata,
  output logic            dack,
  output logic      [7:0] drdata,
  // Scene control and observation
  input  wire logic       sig_on,
  input  wire logic       cal_on,
  input  wire logic [1:0] shift,
  output logic      [7:0] regs [1:8],
  output logic      [7:0] first_ph,
  output logic      [7:0] first_gn,
  output logic      [7:0] two_at_zero,
  output logic      [7:0] faults
);
  logic       req_q, slow, got_ph, got_gn, fresh;
  logic [1:0] dly;
  logic [6:0] ramp;
  int         since, nrd;

  function automatic int absd(input int a);
    return (a < 0) ? -a : a;
  endfunction

  // Noise rises with gain code; image tone has its minimum at 20/-12
  function automatic logic [6:0] level();
    int s;
    if (sig_on)
      s = 30 + ramp;
    else if (cal_on)
      s = 10 + absd($signed(regs[7]) - 20) + absd($signed(regs[8]) + 12);
    else
      s = 20 + (regs[3][4:0] >> shift);
    return (s > 106) ? 7'h6a : 7'(s);
  endfunction

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {dack, req_q, slow, got_ph, got_gn, fresh, dly, ramp} <= '0;
      {drdata, first_ph, first_gn, two_at_zero, faults} <= '0;
      since <= 0;
      nrd   <= 0;
      for (int i = 1; i <= 8; i++)
        regs[i] <= 8'h00;
    end
    else
    begin
      dack  <= 1'b0;
      req_q <= dreq;
      since <= since + 1;
      if (!sig_on)
        ramp <= 7'h00;
      if (dack)
        drdata <= ~drdata; // Released bus must not keep stale data
      if (dreq && !req_q)
      begin
        dly  <= slow ? 2'h3 : 2'h0;
        slow <= !slow;
        if (cal_on && !dwr && daddr == DEV_STRENGTH)
        begin
          if (since < (fresh ? SETTLE : GAP) - 2)
            faults <= faults + 8'h01;
          nrd   <= nrd + 1;
          since <= 0;
          fresh <= 1'b0;
        end
        if (dwr && daddr inside {DEV_PHASE_COMP, DEV_GAIN_COMP})
        begin
          if (nrd != 0 && nrd != AVG_READS)
            faults <= faults + 8'h01;
          nrd   <= 0;
          since <= 0;
          fresh <= 1'b1;
        end
      end
      else if (dreq && !dack && dly != 2'h0)
        dly <= dly - 2'h1;
      else if (dreq && !dack)
      begin
        dack <= 1'b1;
        if (dwr && daddr inside {[7'h01:7'h08]})
          regs[daddr[3:0]] <= dwdata;
        if (dwr && daddr == DEV_PHASE_COMP && !got_ph)
          {got_ph, first_ph} <= {1'b1, dwdata};
        if (dwr && daddr == DEV_GAIN_COMP && !got_gn)
          {got_gn, first_gn} <= {1'b1, dwdata};
        if (dwr && daddr == DEV_GAIN_THREE && dwdata[4:0] == 5'h00)
          two_at_zero <= regs[2];
        if (!dwr && daddr == DEV_STRENGTH)
        begin
          drdata <= {1'b0, level()};
          ramp   <= ramp + {6'h00, sig_on};
        end
        else if (!dwr && daddr == DEV_STATUS)
          drdata <= {4'h0, int'(level()) > regs[4][4:0] + 8, 3'h0};
        else if (!dwr)
          drdata <= regs[daddr[3:0]];
      end
    end
  end
endmodule

// ### dv/agc_and_image_rejection_calibration_tb.sv
`timescale 1ns/10ps
`define CHK(g, x) \
  begin \
    tests_run++; \
    if ((g) !== (x)) \
    begin \
      mismatches++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x); \
    end \
  end

module agc_and_image_rejection_calibration_tb
  import agc_cal_pkg::*;
;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        dreq, dwr, dack, sig_on, cal_on, e;
  logic [6:0]  daddr;
  logic [7:0]  dwdata, drdata, first_ph, first_gn, two_at_zero, faults;
  logic [7:0]  regs [1:8];
  logic [1:0]  shift;
  int          mismatches, tests_run;

  agc_cal_ctrl #(.SETTLE_CYCLES(40), .GAP_CYCLES(10)) dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dreq(dreq), .dwr(dwr),
    .daddr(daddr), .dwdata(dwdata), .dack(dack), .drdata(drdata));

  dev_model #(.SETTLE(40), .GAP(10)) dev (
    .ref_clk(ref_clk), .rst(rst), .dreq(dreq), .dwr(dwr), .daddr(daddr),
    .dwdata(dwdata), .dack(dack), .drdata(drdata), .sig_on(sig_on),
    .cal_on(cal_on), .shift(shift), .regs(regs), .first_ph(first_ph),
    .first_gn(first_gn), .two_at_zero(two_at_zero), .faults(faults));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    @(posedge ref_clk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic poll(input int idx, input logic v);
    int n;
    n = 0;
    xfer(A_STATUS, 1'b0, 32'h0);
    while (q[idx] !== v && n < 9000)
    begin
      n++;
      xfer(A_STATUS, 1'b0, 32'h0);
    end
    `CHK(q[idx], v)
  endtask

  function automatic logic near(input logic [7:0] v, input int t);
    int d;
    d = int'($signed(v)) - t;
    return d <= 6 && d >= -6;
  endfunction

  task automatic t_regs();
    xfer(A_FILTER, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    xfer(A_STATUS, 1'b0, 32'h0);
    `CHK(q[3:0], 4'h0)
    xfer(A_FILTER, 1'b1, 32'h80);
    xfer(A_MARGIN, 1'b1, 32'h25);
    xfer(A_MARGIN, 1'b0, 32'h0);
    `CHK(q[6:0], 7'h25)
    xfer(12'h014, 1'b0, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0})
    xfer(A_CTRL, 1'b0, 32'h0);
    `CHK(q[2:0], 3'h0)
  endtask

  // Noise floor slope picks the gain code and so the split at 10
  task automatic t_agc(input logic [1:0] sh, input logic [4:0] code,
                       input logic [7:0] two);
    shift  <= sh;
    sig_on <= 1'b0;
    xfer(A_CTRL, 1'b1, 32'h1 << CTRL_AGC);
    poll(ST_HOLD, 1'b1);
    `CHK(two_at_zero, GAIN_TWO_OFF)
    `CHK(regs[3][4:0], code)
    sig_on <= 1'b1;
    xfer(A_CTRL, 1'b1, 32'h1 << CTRL_CONT);
    poll(ST_BUSY, 1'b0);
    `CHK(q[ST_CSENSE], 1'b1)
    `CHK(regs[4], 8'hb6)
    `CHK(regs[3], {3'h2, code})
    `CHK(regs[2], two)
    xfer(A_RESULT, 1'b0, 32'h0);
    `CHK({q[28:24], q[20:16]}, {5'h16, code})
  endtask

  task automatic t_cal();
    // Carrier off, else the model answers with the ramp, not the image
    sig_on <= 1'b0;
    cal_on <= 1'b1;
    xfer(A_CTRL, 1'b1, 32'h1 << CTRL_CAL);
    poll(ST_BUSY, 1'b1);
    poll(ST_BUSY, 1'b0);
    cal_on <= 1'b0;
    `CHK(regs[1], 8'h80)
    `CHK(first_gn, 8'h00)
    `CHK(first_ph, 8'h7f)
    `CHK(faults, 8'h00)
    `CHK(near(regs[7], 20), 1'b1)
    `CHK(near(regs[8], -12), 1'b1)
    xfer(A_RESULT, 1'b0, 32'h0);
    `CHK(q[15:0], {regs[8], regs[7]})
  endtask

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sig_on, cal_on, shift} = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_agc(2'h0, 5'h04, GAIN_TWO_LOW);
    t_agc(2'h3, 5'h1f, GAIN_TWO_HIGH);
    t_cal();
    print_verdict();
  end

  // Whole run is near 14k cycles; this cuts a hang short
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
endmodule
